// *** include/mprs_pkg.sv ***
`default_nettype none
package mprs_pkg;
  // ****************************************************************
  // Clock rate and documented times
  // ****************************************************************
  localparam int CLK_KHZ = 10000;
  localparam int CLK_MHZ = 10;
  localparam int PON_HOLD_MS = 25;
  localparam int POWERUP_MS = 2000;
  localparam int RST_HOLD_MS = 20;
  localparam int TX_ADVANCE_US = 30;
  localparam int TX_TRAIL_US = 10;

  // ****************************************************************
  // Derived cycle counts and counter widths
  // ****************************************************************
  localparam int PON_HOLD_CYC = PON_HOLD_MS * CLK_KHZ;
  localparam int POWERUP_CYC = POWERUP_MS * CLK_KHZ;
  localparam int RST_HOLD_CYC = RST_HOLD_MS * CLK_KHZ;
  localparam int TX_ADVANCE_CYC = TX_ADVANCE_US * CLK_MHZ;
  localparam int TX_TRAIL_CYC = TX_TRAIL_US * CLK_MHZ;
  localparam int TMR_W = 25;
  localparam int RST_W = 18;
  localparam int TX_W = 9;

  // ****************************************************************
  // Working memory shape
  // ****************************************************************
  localparam int MEM_DEPTH = 8;
  localparam int MEM_AW = 3;
  localparam int MEM_DW = 8;
  localparam logic [7:0] MEM_RESET = 8'h00;

  typedef enum logic [1:0] {
    MPRS_OFF,
    MPRS_TRIGGER,
    MPRS_POWERUP,
    MPRS_ON
  } mprs_pwr_t;

  typedef enum logic [1:0] {
    MPRS_TX_IDLE,
    MPRS_TX_ADVANCE,
    MPRS_TX_ACTIVE,
    MPRS_TX_TRAIL
  } mprs_tx_t;

  typedef enum logic [1:0] {
    MPRS_H_IDLE,
    MPRS_H_PON,
    MPRS_H_WAIT,
    MPRS_H_RST
  } mprs_host_t;
endpackage
`default_nettype wire

// *** include/mprs_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface mprs_if;
  logic pon_o;
  logic pon_oe;
  logic pon_pullup;
  logic rst_o;
  logic rst_oe;
  logic io_supply_alive;
  logic tx_indicator;
  logic serial_clear_to_send;
  logic fast_clock_output;
  logic slow_clock_output;
  logic pon_level;
  logic rst_level;

  // ****************************************************************
  // Open-drain wire levels
  // ****************************************************************
  // The request line floats to the module's pull-up level when nobody sinks it.
  assign pon_level = (pon_oe & ~pon_o) ? 1'b0 : pon_pullup;
  // The reset line has an always-present pull-up of its own.
  assign rst_level = ~(rst_oe & ~rst_o);

  modport dev (
    input  pon_level,
    input  rst_level,
    output pon_pullup,
    output io_supply_alive,
    output tx_indicator,
    output serial_clear_to_send,
    output fast_clock_output,
    output slow_clock_output
  );

  modport host (
    input  pon_level,
    input  rst_level,
    input  io_supply_alive,
    input  tx_indicator,
    input  serial_clear_to_send,
    output pon_o,
    output pon_oe,
    output rst_o,
    output rst_oe
  );
endinterface
`default_nettype wire

// *** logic/mprs_device.sv ***
`timescale 1ns/1ps
`default_nettype none
module mprs_device #(
  parameter int unsigned PON_HOLD_CYC = mprs_pkg::PON_HOLD_CYC,
  parameter int unsigned POWERUP_CYC  = mprs_pkg::POWERUP_CYC,
  parameter int unsigned RST_HOLD_CYC = mprs_pkg::RST_HOLD_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  mprs_if.dev                              link,
  input  wire logic                        battery_present,
  input  wire logic                        power_off_command,
  input  wire logic                        tx_request,
  output logic                             tx_grant,
  input  wire logic                        fast_clock_enable,
  input  wire logic                        slow_clock_enable,
  input  wire logic                        fast_clock_source,
  input  wire logic                        slow_clock_source,
  input  wire logic                        mem_we,
  input  wire logic [mprs_pkg::MEM_AW-1:0] mem_addr,
  input  wire logic [mprs_pkg::MEM_DW-1:0] mem_wdata,
  output logic      [mprs_pkg::MEM_DW-1:0] mem_rdata,
  output logic                             reset_cleared
);

  localparam int TW = mprs_pkg::TMR_W;
  localparam int RW = mprs_pkg::RST_W;
  localparam int XW = mprs_pkg::TX_W;

  mprs_pkg::mprs_pwr_t     pwr_ff;
  mprs_pkg::mprs_pwr_t     nxt_pwr;
  logic [TW-1:0]           tmr_ff;
  logic [TW-1:0]           nxt_tmr;
  logic [RW-1:0]           rcnt_ff;
  logic [RW-1:0]           nxt_rcnt;
  logic                    rdone_ff;
  logic                    nxt_rdone;
  logic                    clear_now;
  logic                    alive_ff;
  logic                    cts_ff;
  logic                    clr_ff;
  logic                    fast_en_ff;
  logic                    slow_en_ff;
  logic                    pon_low;
  logic                    rst_low;
  mprs_pkg::mprs_tx_t      tx_ff;
  mprs_pkg::mprs_tx_t      nxt_tx;
  logic [XW-1:0]           txc_ff;
  logic [XW-1:0]           nxt_txc;
  logic                    tx_ind_ff;
  logic                    grant_ff;
  logic [mprs_pkg::MEM_DW-1:0] mem_ff  [mprs_pkg::MEM_DEPTH];
  logic [mprs_pkg::MEM_DW-1:0] nxt_mem [mprs_pkg::MEM_DEPTH];
  logic [mprs_pkg::MEM_DW-1:0] rdata_ff;

  function automatic logic is_on(input mprs_pkg::mprs_pwr_t s);
    is_on = (s == mprs_pkg::MPRS_POWERUP) || (s == mprs_pkg::MPRS_ON);
  endfunction

  assign pon_low = ~link.pon_level;
  assign rst_low = ~link.rst_level;

  // ****************************************************************
  // Power and reset sequencing
  // ****************************************************************
  always_comb begin
    nxt_pwr   = pwr_ff;
    nxt_tmr   = tmr_ff;
    nxt_rcnt  = rcnt_ff;
    nxt_rdone = rdone_ff;
    clear_now = 1'b0;
    // A reset pulse acts once, at the moment it has been low long enough.
    if (rst_low) begin
      if (!rdone_ff) begin
        if (rcnt_ff == RW'(RST_HOLD_CYC - 1)) begin
          nxt_rdone = 1'b1;
          clear_now = 1'b1;
        end else begin
          nxt_rcnt = rcnt_ff + 1'b1;
        end
      end
    end else begin
      nxt_rcnt  = '0;
      nxt_rdone = 1'b0;
    end
    case (pwr_ff)
      mprs_pkg::MPRS_OFF: begin
        if (pon_low) begin
          nxt_pwr = mprs_pkg::MPRS_TRIGGER;
          nxt_tmr = TW'(1);
        end
      end
      mprs_pkg::MPRS_TRIGGER: begin
        if (!pon_low) begin
          nxt_pwr = mprs_pkg::MPRS_OFF;
          nxt_tmr = '0;
        end else begin
          nxt_tmr = tmr_ff + 1'b1;
          if (tmr_ff >= TW'(PON_HOLD_CYC - 1)) begin
            nxt_pwr = mprs_pkg::MPRS_POWERUP;
          end
        end
      end
      mprs_pkg::MPRS_POWERUP: begin
        // The request line is not looked at here or in the on state.
        nxt_tmr = tmr_ff + 1'b1;
        if (tmr_ff >= TW'(POWERUP_CYC - 1)) begin
          nxt_pwr = mprs_pkg::MPRS_ON;
        end
      end
      mprs_pkg::MPRS_ON: begin
        nxt_pwr = mprs_pkg::MPRS_ON;
      end
      default: begin
        nxt_pwr = mprs_pkg::MPRS_OFF;
        nxt_tmr = '0;
      end
    endcase
    if (power_off_command && is_on(pwr_ff)) begin
      nxt_pwr = mprs_pkg::MPRS_OFF;
      nxt_tmr = '0;
    end
    if (clear_now) begin
      if (pon_low) begin
        // The falling edge of reset was this many cycles ago.
        nxt_pwr = mprs_pkg::MPRS_POWERUP;
        nxt_tmr = TW'(RST_HOLD_CYC);
      end else begin
        nxt_pwr = mprs_pkg::MPRS_OFF;
        nxt_tmr = '0;
      end
    end
    if (!battery_present) begin
      nxt_pwr = mprs_pkg::MPRS_OFF;
      nxt_tmr = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ff     <= mprs_pkg::MPRS_OFF;
      tmr_ff     <= '0;
      rcnt_ff    <= '0;
      rdone_ff   <= 1'b0;
      alive_ff   <= 1'b0;
      cts_ff     <= 1'b1;
      clr_ff     <= 1'b0;
      fast_en_ff <= 1'b0;
      slow_en_ff <= 1'b0;
    end else begin
      pwr_ff     <= nxt_pwr;
      tmr_ff     <= nxt_tmr;
      rcnt_ff    <= nxt_rcnt;
      rdone_ff   <= nxt_rdone;
      alive_ff   <= is_on(nxt_pwr);
      cts_ff     <= (nxt_pwr != mprs_pkg::MPRS_ON);
      clr_ff     <= clear_now;
      fast_en_ff <= fast_clock_enable && is_on(nxt_pwr);
      slow_en_ff <= slow_clock_enable && is_on(nxt_pwr);
    end
  end

  // ****************************************************************
  // Transmit indicator timing
  // ****************************************************************
  always_comb begin
    nxt_tx  = tx_ff;
    nxt_txc = txc_ff + 1'b1;
    case (tx_ff)
      mprs_pkg::MPRS_TX_IDLE: begin
        nxt_txc = '0;
        if (tx_request) begin
          nxt_tx = mprs_pkg::MPRS_TX_ADVANCE;
        end
      end
      mprs_pkg::MPRS_TX_ADVANCE: begin
        if (!tx_request) begin
          nxt_tx  = mprs_pkg::MPRS_TX_TRAIL;
          nxt_txc = '0;
        end else if (txc_ff == XW'(mprs_pkg::TX_ADVANCE_CYC - 1)) begin
          nxt_tx = mprs_pkg::MPRS_TX_ACTIVE;
        end
      end
      mprs_pkg::MPRS_TX_ACTIVE: begin
        nxt_txc = '0;
        if (!tx_request) begin
          nxt_tx = mprs_pkg::MPRS_TX_TRAIL;
        end
      end
      mprs_pkg::MPRS_TX_TRAIL: begin
        // A new request restarts the full advance so the lead is never short.
        if (tx_request) begin
          nxt_tx  = mprs_pkg::MPRS_TX_ADVANCE;
          nxt_txc = '0;
        end else if (txc_ff == XW'(mprs_pkg::TX_TRAIL_CYC - 1)) begin
          nxt_tx = mprs_pkg::MPRS_TX_IDLE;
        end
      end
      default: begin
        nxt_tx = mprs_pkg::MPRS_TX_IDLE;
      end
    endcase
    if (nxt_pwr != mprs_pkg::MPRS_ON) begin
      nxt_tx  = mprs_pkg::MPRS_TX_IDLE;
      nxt_txc = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ff     <= mprs_pkg::MPRS_TX_IDLE;
      txc_ff    <= '0;
      tx_ind_ff <= 1'b0;
      grant_ff  <= 1'b0;
    end else begin
      tx_ff     <= nxt_tx;
      txc_ff    <= nxt_txc;
      tx_ind_ff <= (nxt_tx != mprs_pkg::MPRS_TX_IDLE);
      grant_ff  <= (nxt_tx == mprs_pkg::MPRS_TX_ACTIVE);
    end
  end

  // ****************************************************************
  // Working memory
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < mprs_pkg::MEM_DEPTH; i++) begin
      nxt_mem[i] = clear_now ? mprs_pkg::MEM_RESET : mem_ff[i];
    end
    if (!clear_now && mem_we && is_on(pwr_ff)) begin
      nxt_mem[mem_addr] = mem_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < mprs_pkg::MEM_DEPTH; i++) begin
        mem_ff[i] <= mprs_pkg::MEM_RESET;
      end
      rdata_ff <= mprs_pkg::MEM_RESET;
    end else begin
      for (int i = 0; i < mprs_pkg::MEM_DEPTH; i++) begin
        mem_ff[i] <= nxt_mem[i];
      end
      rdata_ff <= clear_now ? mprs_pkg::MEM_RESET : mem_ff[mem_addr];
    end
  end

  // The pull-up exists only while the battery feeds its regulator.
  assign link.pon_pullup           = battery_present;
  assign link.io_supply_alive      = alive_ff;
  assign link.tx_indicator         = tx_ind_ff;
  assign link.serial_clear_to_send = cts_ff;
  // Plain gating may clip the first or last source pulse; fine for a clock tap.
  assign link.fast_clock_output    = fast_clock_source & fast_en_ff;
  assign link.slow_clock_output    = slow_clock_source & slow_en_ff;
  assign tx_grant                  = grant_ff;
  assign mem_rdata                 = rdata_ff;
  assign reset_cleared             = clr_ff;

endmodule
`default_nettype wire

// *** logic/mprs_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module mprs_host #(
  parameter int unsigned PON_HOLD_CYC = mprs_pkg::PON_HOLD_CYC,
  parameter int unsigned POWERUP_CYC  = mprs_pkg::POWERUP_CYC,
  parameter int unsigned RST_HOLD_CYC = mprs_pkg::RST_HOLD_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  mprs_if.host      link,
  input  wire logic power_on_cmd,
  input  wire logic reset_cmd,
  input  wire logic reset_restart,
  output logic      host_busy,
  output logic      module_on,
  output logic      module_ready,
  output logic      tx_seen
);

  localparam int TW = mprs_pkg::TMR_W;

  mprs_pkg::mprs_host_t st_ff;
  mprs_pkg::mprs_host_t nxt_st;
  logic [TW-1:0]        tmr_ff;
  logic [TW-1:0]        nxt_tmr;
  logic                 restart_ff;
  logic                 nxt_restart;
  logic                 ready_ff;
  logic                 nxt_ready;
  logic                 pon_oe_ff;
  logic                 rst_oe_ff;
  logic                 on_ff;
  logic                 tx_ff;

  // ****************************************************************
  // Request sequencing
  // ****************************************************************
  always_comb begin
    nxt_st      = st_ff;
    nxt_tmr     = tmr_ff;
    nxt_restart = restart_ff;
    nxt_ready   = ready_ff && link.io_supply_alive;
    case (st_ff)
      mprs_pkg::MPRS_H_IDLE: begin
        nxt_tmr = '0;
        if (power_on_cmd) begin
          nxt_st    = mprs_pkg::MPRS_H_PON;
          nxt_ready = 1'b0;
        end else if (reset_cmd) begin
          nxt_st      = mprs_pkg::MPRS_H_RST;
          nxt_restart = reset_restart;
          nxt_ready   = 1'b0;
        end
      end
      mprs_pkg::MPRS_H_PON: begin
        nxt_tmr = tmr_ff + 1'b1;
        if (tmr_ff == TW'(PON_HOLD_CYC - 1)) begin
          nxt_st = mprs_pkg::MPRS_H_WAIT;
        end
      end
      mprs_pkg::MPRS_H_RST: begin
        nxt_tmr = tmr_ff + 1'b1;
        if (tmr_ff == TW'(RST_HOLD_CYC - 1)) begin
          nxt_st = restart_ff ? mprs_pkg::MPRS_H_WAIT : mprs_pkg::MPRS_H_IDLE;
        end
      end
      mprs_pkg::MPRS_H_WAIT: begin
        // The timer keeps running from the falling edge of the request.
        if (tmr_ff < TW'(POWERUP_CYC - 1)) begin
          nxt_tmr = tmr_ff + 1'b1;
        end else if (!link.serial_clear_to_send) begin
          nxt_st    = mprs_pkg::MPRS_H_IDLE;
          nxt_ready = 1'b1;
        end else if (!link.io_supply_alive) begin
          // A module without supply never answers; give up instead of hanging.
          nxt_st = mprs_pkg::MPRS_H_IDLE;
        end
      end
      default: begin
        nxt_st = mprs_pkg::MPRS_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff      <= mprs_pkg::MPRS_H_IDLE;
      tmr_ff     <= '0;
      restart_ff <= 1'b0;
      ready_ff   <= 1'b0;
      pon_oe_ff  <= 1'b0;
      rst_oe_ff  <= 1'b0;
      on_ff      <= 1'b0;
      tx_ff      <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      tmr_ff     <= nxt_tmr;
      restart_ff <= nxt_restart;
      ready_ff   <= nxt_ready;
      pon_oe_ff  <= (nxt_st == mprs_pkg::MPRS_H_PON) ||
                    ((nxt_st == mprs_pkg::MPRS_H_RST) && nxt_restart);
      rst_oe_ff  <= (nxt_st == mprs_pkg::MPRS_H_RST);
      on_ff      <= link.io_supply_alive;
      tx_ff      <= link.tx_indicator;
    end
  end

  // Open-drain: only ever sink, never drive high.
  assign link.pon_o  = 1'b0;
  assign link.pon_oe = pon_oe_ff;
  assign link.rst_o  = 1'b0;
  assign link.rst_oe = rst_oe_ff;
  assign host_busy    = (st_ff != mprs_pkg::MPRS_H_IDLE);
  assign module_on    = on_ff;
  assign module_ready = ready_ff;
  assign tx_seen      = tx_ff;

endmodule
`default_nettype wire

// *** tb/mprs_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module mprs_checker #(
  parameter int unsigned PON_HOLD_CYC = mprs_pkg::PON_HOLD_CYC,
  parameter int unsigned POWERUP_CYC  = mprs_pkg::POWERUP_CYC,
  parameter int unsigned RST_HOLD_CYC = mprs_pkg::RST_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pon_level,
  input wire logic rst_level,
  input wire logic io_supply_alive,
  input wire logic tx_indicator,
  input wire logic serial_clear_to_send,
  input wire logic fast_clock_output,
  input wire logic slow_clock_output
);
  // ****************************************************************
  // Run-length and elapsed-time counters
  // ****************************************************************
  logic [31:0] pon_run_ff;
  logic [31:0] rst_run_ff;
  logic [31:0] since_ff;
  logic [31:0] nxt_pon_run;
  logic [31:0] nxt_rst_run;
  logic [31:0] nxt_since;

  // The elapsed count restarts on the first low sample of the request line or the reset line.
  always_comb begin
    nxt_pon_run = pon_level ? 32'h0 : pon_run_ff + 32'h1;
    nxt_rst_run = rst_level ? 32'h0 : rst_run_ff + 32'h1;
    nxt_since = since_ff + 32'h1;
    if ((!pon_level && pon_run_ff == 32'h0) || (!rst_level && rst_run_ff == 32'h0)) begin
      nxt_since = 32'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pon_run_ff <= 32'h0;
      rst_run_ff <= 32'h0;
      since_ff <= 32'h0;
    end else begin
      pon_run_ff <= nxt_pon_run;
      rst_run_ff <= nxt_rst_run;
      since_ff <= nxt_since;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_pon_held;
    pon_run_ff == PON_HOLD_CYC && rst_level;
  endsequence

  // The device decides on the sample that completes the hold, so look at that very edge.
  sequence s_reset_taken;
    rst_run_ff == RST_HOLD_CYC - 1 && !rst_level;
  endsequence

  chk_pon_turns_on: assert property (s_pon_held |-> ##[1:3] io_supply_alive)
    else $error("supply status did not rise after a full request");
  chk_pon_no_off: assert property (
    io_supply_alive && rst_level && $fell(pon_level) |-> io_supply_alive [*8])
    else $error("request line switched the module off");
  chk_reset_off: assert property (
    s_reset_taken ##0 pon_level |-> ##[1:3] !io_supply_alive)
    else $error("reset with request high did not power off");
  chk_reset_restart: assert property (
    s_reset_taken ##0 !pon_level |-> ##[1:3] (io_supply_alive && serial_clear_to_send))
    else $error("reset with request low did not restart");
  chk_ready_delay: assert property (
    $fell(serial_clear_to_send) |-> since_ff + 32'h2 >= POWERUP_CYC && since_ff <= POWERUP_CYC + 2)
    else $error("command interface ready at the wrong time");
  chk_off_not_ready: assert property (
    !io_supply_alive && !$past(io_supply_alive) |-> serial_clear_to_send)
    else $error("ready shown while off");
  chk_tx_needs_on: assert property (!io_supply_alive |-> !tx_indicator)
    else $error("transmit indicator high while off");
  chk_clk_gated_off: assert property (
    !io_supply_alive && !$past(io_supply_alive) && !$past(io_supply_alive, 2)
    |-> !fast_clock_output && !slow_clock_output)
    else $error("clock output running while off");
  chk_tx_min_high: assert property ($rose(tx_indicator) |-> tx_indicator [*8])
    else $error("transmit indicator pulse too short");
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int unsigned P = 25;
  localparam int unsigned U = 200;
  localparam int unsigned R = 20;

  logic       clk, rst_n, bat, poff, txr, fen, sen, fsrc, ssrc, mwe, pcmd, rcmd, rrst;
  logic [2:0] maddr;
  logic [7:0] mwd;
  logic [7:0] mrd;
  logic       txg, rclr, hbusy, mon, mrdy, txs;
  int         bad_count;
  int         cmp_count;

  mprs_if lk ();
  mprs_if lk2 ();

  mprs_device #(.PON_HOLD_CYC(P), .POWERUP_CYC(U), .RST_HOLD_CYC(R)) i_mprs_device (
    .clk(clk), .rst_n(rst_n), .link(lk), .battery_present(bat), .power_off_command(poff),
    .tx_request(txr), .tx_grant(txg), .fast_clock_enable(fen), .slow_clock_enable(sen),
    .fast_clock_source(fsrc), .slow_clock_source(ssrc), .mem_we(mwe), .mem_addr(maddr),
    .mem_wdata(mwd), .mem_rdata(mrd), .reset_cleared(rclr));
  // The second device faces the bench directly so that short pulses can be sent.
  mprs_device #(.PON_HOLD_CYC(P), .POWERUP_CYC(U), .RST_HOLD_CYC(R)) i_mprs_device_2 (
    .clk(clk), .rst_n(rst_n), .link(lk2), .battery_present(bat), .power_off_command(poff),
    .tx_request(txr), .tx_grant(), .fast_clock_enable(fen), .slow_clock_enable(sen),
    .fast_clock_source(fsrc), .slow_clock_source(ssrc), .mem_we(mwe), .mem_addr(maddr),
    .mem_wdata(mwd), .mem_rdata(), .reset_cleared());
  mprs_host #(.PON_HOLD_CYC(P), .POWERUP_CYC(U), .RST_HOLD_CYC(R)) i_mprs_host (
    .clk(clk), .rst_n(rst_n), .link(lk), .power_on_cmd(pcmd), .reset_cmd(rcmd),
    .reset_restart(rrst), .host_busy(hbusy), .module_on(mon), .module_ready(mrdy),
    .tx_seen(txs));
  mprs_checker #(.PON_HOLD_CYC(P), .POWERUP_CYC(U), .RST_HOLD_CYC(R)) i_mprs_checker (
    .clk(clk), .rst_n(rst_n), .pon_level(lk.pon_level), .rst_level(lk.rst_level),
    .io_supply_alive(lk.io_supply_alive), .tx_indicator(lk.tx_indicator),
    .serial_clear_to_send(lk.serial_clear_to_send), .fast_clock_output(lk.fast_clock_output),
    .slow_clock_output(lk.slow_clock_output));

  always #50 clk = ~clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_pullup();
    check(lk.pon_level, 1'b1);
    bat = 1'b0;
    tick();
    check(lk.pon_pullup, 1'b0);
    bat = 1'b1;
    tick();
    check(lk.pon_pullup, 1'b1);
  endtask

  task automatic t_power_on();
    int n;
    pcmd = 1'b1;
    tick();
    pcmd = 1'b0;
    n = 1;
    while (lk.io_supply_alive !== 1'b1 && n < 60) begin
      tick();
      n++;
    end
    check(n >= P && n <= P + 4, 1'b1);
    check({lk.serial_clear_to_send, mrdy}, 2'b10);
    while (lk.serial_clear_to_send !== 1'b0 && n < U + 60) begin
      tick();
      n++;
    end
    check(n >= U && n <= U + 5, 1'b1);
    tick(3);
    check({mon, mrdy, lk.pon_level}, 3'b111);
  endtask

  task automatic t_pon_ignored();
    pcmd = 1'b1;
    tick();
    pcmd = 1'b0;
    tick(40);
    check({lk.io_supply_alive, lk.serial_clear_to_send}, 2'b10);
  endtask

  task automatic t_clocks();
    for (int i = 0; i < 4; i++) begin
      {fen, sen} = i[1:0];
      tick(2);
      check({lk.fast_clock_output, lk.slow_clock_output}, i[1:0]);
    end
    {fsrc, ssrc} = 2'h0;
    tick();
    check({lk.fast_clock_output, lk.slow_clock_output}, 2'h0);
    {fsrc, ssrc} = 2'h3;
  endtask

  task automatic t_tx();
    int n;
    txr = 1'b1;
    tick();
    check({lk.tx_indicator, txg}, 2'b10);
    n = 0;
    while (txg !== 1'b1 && n < 400) begin
      tick();
      n++;
    end
    check(n, mprs_pkg::TX_ADVANCE_CYC);
    txr = 1'b0;
    tick();
    check({lk.tx_indicator, txg}, 2'b10);
    n = 1;
    while (lk.tx_indicator !== 1'b0 && n < 200) begin
      tick();
      n++;
    end
    check(n >= mprs_pkg::TX_TRAIL_CYC && n <= mprs_pkg::TX_TRAIL_CYC + 1, 1'b1);
    check(txs, 1'b1);
    // An aborted advance goes to the trail, and a new request there restarts the full lead.
    txr = 1'b1;
    tick(5);
    txr = 1'b0;
    tick(50);
    check({lk.tx_indicator, txg}, 2'b10);
    txr = 1'b1;
    tick(mprs_pkg::TX_ADVANCE_CYC);
    check({lk.tx_indicator, txg}, 2'b10);
    tick();
    check(txg, 1'b1);
    txr = 1'b0;
    tick();
    check(txg, 1'b0);
  endtask

  task automatic t_restart();
    int n;
    for (int a = 0; a < 8; a++) begin
      mwe = 1'b1;
      maddr = a[2:0];
      mwd = 8'hA0 | a[7:0];
      tick();
    end
    mwe = 1'b0;
    maddr = 3'h5;
    tick(2);
    check(mrd, 8'hA5);
    rrst = 1'b1;
    rcmd = 1'b1;
    tick();
    rcmd = 1'b0;
    n = 1;
    while (rclr !== 1'b1 && n < R + 10) begin
      tick();
      n++;
    end
    check(n >= R && n <= R + 4, 1'b1);
    check({lk.io_supply_alive, lk.serial_clear_to_send}, 2'b11);
    for (int a = 0; a < 8; a++) begin
      maddr = a[2:0];
      tick();
      n++;
      check(mrd, 8'h00);
    end
    while (lk.serial_clear_to_send !== 1'b0 && n < U + 60) begin
      tick();
      n++;
    end
    check(n >= U && n <= U + 5, 1'b1);
  endtask

  task automatic t_emergency_off();
    int n;
    // The host takes a command only while idle, so let it finish its wait first.
    while (hbusy === 1'b1) begin
      tick();
    end
    rrst = 1'b0;
    rcmd = 1'b1;
    tick();
    rcmd = 1'b0;
    n = 1;
    while (lk.io_supply_alive !== 1'b0 && n < R + 10) begin
      tick();
      n++;
    end
    check(n >= R && n <= R + 4, 1'b1);
    tick(3);
    check({mon, lk.pon_level, lk.tx_indicator, lk.serial_clear_to_send}, 4'h5);
  endtask

  task automatic t_power_off();
    poff = 1'b1;
    tick();
    poff = 1'b0;
    tick(2);
    check(lk.io_supply_alive, 1'b0);
  endtask

  // Short pulses are refused; only full-length ones change the state.
  task automatic t_faults();
    lk2.pon_oe = 1'b1;
    tick(P - 5);
    lk2.pon_oe = 1'b0;
    tick(5);
    check(lk2.io_supply_alive, 1'b0);
    lk2.pon_oe = 1'b1;
    tick(P + 3);
    lk2.pon_oe = 1'b0;
    tick();
    check(lk2.io_supply_alive, 1'b1);
    lk2.rst_oe = 1'b1;
    tick(R - 5);
    lk2.rst_oe = 1'b0;
    tick(5);
    check(lk2.io_supply_alive, 1'b1);
    lk2.rst_oe = 1'b1;
    tick(R + 3);
    lk2.rst_oe = 1'b0;
    tick();
    check(lk2.io_supply_alive, 1'b0);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    {clk, rst_n, poff, txr, fen, sen, mwe, pcmd, rcmd, rrst} = '0;
    {bat, fsrc, ssrc} = 3'h7;
    {lk2.pon_o, lk2.pon_oe, lk2.rst_o, lk2.rst_oe} = 4'h0;
    maddr = 3'h0;
    mwd = 8'h00;
    bad_count = 0;
    cmp_count = 0;
    tick(10);
    rst_n = 1'b1;
    tick();
    t_pullup();
    t_faults();
    t_power_on();
    t_pon_ignored();
    t_clocks();
    t_tx();
    t_restart();
    t_emergency_off();
    t_power_on();
    t_power_off();
    wrap_up();
  end

  // The span leaves ample room over the roughly 1600 cycles the scenarios need.
  initial begin
    #(5000 * 100);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
